// ===== mdo_gen.sv
// one output pin generator: phase accumulator for frequency and pwm
`timescale 1ns/100ps
module mdo_gen (
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire mdo_pkg::mdo_drive_t drv,
   output logic                   pin,
   output logic [31:0]            phase
);
   logic [31:0] step;
   logic        next_pin;

   // step scales with hz so one wrap of the phase is one output period
   assign step = 32'((32'(drv.hz) * 32'(mdo_pkg::NCO_K)) >> mdo_pkg::NCO_SHIFT);

   // phase accumulator; held at zero while idle so a restart is glitch free
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         phase <= 32'h0;
      end else if (!drv.en) begin
         phase <= 32'h0;
      end else begin
         phase <= phase + step;
      end
   end

   always_comb begin
      if (!drv.en) begin
         next_pin = 1'b0;
      end else if (drv.pwm) begin
         next_pin = {1'b0, phase[31:16]} < drv.duty;
      end else begin
         next_pin = phase[31];             // square wave, 50 % duty
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin <= 1'b0;
      end else begin
         pin <= next_pin;
      end
   end

   property p_duty_full;
      @(posedge pclk) disable iff (!presetn)
      (drv.en && drv.pwm && drv.duty == mdo_pkg::D_FULL) |=> pin;
   endproperty
   a_duty_full: assert property (p_duty_full) else $error("full duty did not hold pin high");

   property p_duty_zero;
      @(posedge pclk) disable iff (!presetn)
      (drv.en && drv.pwm && drv.duty == 17'h0) |=> !pin;
   endproperty
   a_duty_zero: assert property (p_duty_zero) else $error("zero duty drove pin high");
endmodule

// ===== mdo_meter.sv
// partner model: receiver that times the modulated output pin
`timescale 1ns/100ps
module mdo_meter (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        pin,
   output logic [31:0]      period,
   output logic [31:0]      high_t
);
   logic        pin_d;
   logic [31:0] cnt;
   logic [31:0] hcnt;
   // restart on every rising edge; only full periods are reported, so a
   // mode change shows up one period late
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_d <= 1'b0;
         cnt <= 32'h0;
         hcnt <= 32'h0;
         period <= 32'h0;
         high_t <= 32'h0;
      end else begin
         pin_d <= pin;
         if (pin && !pin_d) begin
            period <= cnt;
            high_t <= hcnt;
            cnt <= 32'h1;
            hcnt <= 32'h1;
         end else begin
            cnt <= cnt + 32'h1;
            hcnt <= hcnt + {31'h0, pin};
         end
      end
   end
endmodule

// ===== mdo_pkg.sv
// package: constants, register map and carrier types of the modulated digital output
package mdo_pkg;
   localparam int unsigned CLK_HZ    = 250_000_000;  // pclk rate
   localparam int          NCO_SHIFT = 8;
   // phase step per hz, scaled by 2^NCO_SHIFT
   localparam logic [15:0] NCO_K     = 16'((64'd1 << (32 + NCO_SHIFT)) / CLK_HZ);
   localparam int          VW        = 16;            // channel value width, 0..ffff = 0..100 %
   localparam int          HZW       = 14;            // frequency field width in hz
   localparam logic [VW-1:0]  V_FULL  = 16'hffff;
   localparam logic [VW:0]    D_FULL  = 17'h10000;    // duty that keeps the pin high
   localparam logic [VW-1:0]  T_MID   = 16'h8000;     // trim temperature centre
   localparam logic [7:0]     FMIN_LO = 8'h64;        // 100 hz
   localparam logic [7:0]     FMIN_HI = 8'hff;        // 255 hz
   localparam logic [HZW-1:0] FMAX_LO = 14'h03e8;     // 1000 hz
   localparam logic [HZW-1:0] FMAX_HI = 14'h2710;     // 10000 hz
   localparam logic [HZW-1:0] HZ_SAT  = 14'h3fff;
   // pwm base frequencies in hz, by selector
   localparam logic [HZW-1:0] BASE_HZ [8] = '{14'h00c8, 14'h01f4, 14'h03e8, 14'h05dc,
                                              14'h07d0, 14'h09c4, 14'h1388, 14'h3a98};
   // register byte offsets
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_SRC  = 8'h04;
   localparam logic [7:0] A_FREQ = 8'h08;
   localparam logic [7:0] A_PWM  = 8'h0c;
   localparam logic [7:0] A_STIM = 8'h10;
   localparam logic [7:0] A_TOFF = 8'h14;
   localparam logic [7:0] A_TGN  = 8'h18;
   localparam logic [7:0] A_TSOT = 8'h1c;
   localparam logic [7:0] A_STAT = 8'h20;
   // field positions
   localparam int F_INV = 2, F_TRIM = 3, F_TSEL = 4;   // ctrl; type in [1:0], tsel [5:4]
   localparam int F_SRC1 = 4;                            // src; pin 0 in [2:0]
   localparam int F_FMAX = 16;                           // freq; min in [7:0]
   localparam int F_SPIN = 16, F_SON = 31;               // stim; value in [15:0]
   typedef enum logic [1:0] {
      MDO_OFF = 2'b00,
      MDO_FM  = 2'b01,
      MDO_PWM = 2'b10
   } mdo_type_t;
   localparam logic [2:0] SRC_NONE = 3'h0;
   localparam logic [2:0] SRC_LAST = 3'h6;               // 1..3 sensor, 4..6 temperature
   localparam logic [2:0] SRC_TEMP = 3'h4;
   // conditioned channel values: [0..2] sensor 1..3, [3..5] temperature 1..3
   typedef struct packed {
      logic [5:0][VW-1:0] val;
   } mdo_chan_t;
   // per-pin drive request towards the generator
   typedef struct packed {
      logic           en;
      logic           pwm;
      logic [HZW-1:0] hz;
      logic [VW:0]    duty;
   } mdo_drive_t;
endpackage

// ===== mdo_top.sv
// modulated digital output: apb registers, source select, fm/pwm mapping, trim
// Functional notes
// - output type: off, frequency or pwm
// - each pin picks unused, sensor or temperature
// - fm range min 100-255, max 1000-10000 hz
// - normal mapping: full stimulus keeps pin high
// - inverted mapping: full stimulus keeps pin low
// - pwm base frequency from discrete 200hz-15khz set
// - applied stimulus replaces measured value on pin
// - trim corrects fm with offset, gain, square
//
// The address map and register access over APB were decided locally.
`timescale 1ns/100ps
module mdo_top (
   input  wire logic                pclk,
   input  wire logic                presetn,
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [7:0]          paddr,
   input  wire logic [31:0]         pwdata,
   output logic [31:0]              prdata,
   output logic                     pready,
   output logic                     pslverr,
   input  wire mdo_pkg::mdo_chan_t  chan,
   output logic [1:0]               pin_out,
   output logic [1:0]               pin_oe
);
   mdo_pkg::mdo_type_t      out_type;
   logic                    map_inv;
   logic                    trim_en;
   logic [1:0]              trim_sel;
   logic [1:0][2:0]         src;
   logic [7:0]              fmin;
   logic [mdo_pkg::HZW-1:0] fmax;
   logic [2:0]              base_sel;
   logic [15:0]             stim_val;
   logic                    stim_pin;
   logic                    stim_on;
   logic signed [15:0]      trim_off;
   logic signed [15:0]      trim_gain;
   logic signed [15:0]      trim_sot;
   logic                    wr_en;
   logic                    rd_en;
   logic                    hit;
   logic signed [16:0]      t_dev;
   logic signed [31:0]      t_sq;
   logic signed [31:0]      trim_corr;
   mdo_pkg::mdo_drive_t     drv [2];

   assign wr_en  = psel && penable && pwrite;
   assign rd_en  = psel && !penable && !pwrite;
   assign pready = 1'b1;                   // zero wait states
   assign hit    = paddr inside {mdo_pkg::A_CTRL, mdo_pkg::A_SRC, mdo_pkg::A_FREQ, mdo_pkg::A_PWM,
                                 mdo_pkg::A_STIM, mdo_pkg::A_TOFF, mdo_pkg::A_TGN, mdo_pkg::A_TSOT,
                                 mdo_pkg::A_STAT};
   assign pslverr = psel && penable && !hit;

   // register writes; range fields clamp so the fm limits can never leave their bands
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out_type  <= mdo_pkg::MDO_OFF;
         map_inv   <= 1'b0;
         trim_en   <= 1'b0;
         trim_sel  <= 2'h0;
         src       <= '0;
         fmin      <= mdo_pkg::FMIN_LO;
         fmax      <= mdo_pkg::FMAX_LO;
         base_sel  <= 3'h2;                // 1 khz
         stim_val  <= 16'h0;
         stim_pin  <= 1'b0;
         stim_on   <= 1'b0;
         trim_off  <= 16'sh0;
         trim_gain <= 16'sh0;
         trim_sot  <= 16'sh0;
      end else if (wr_en) begin
         unique case (paddr)
            mdo_pkg::A_CTRL: begin
               out_type <= (pwdata[1:0] == 2'b11) ? mdo_pkg::MDO_OFF : mdo_pkg::mdo_type_t'(pwdata[1:0]);
               map_inv  <= pwdata[mdo_pkg::F_INV];
               trim_en  <= pwdata[mdo_pkg::F_TRIM];
               trim_sel <= (pwdata[mdo_pkg::F_TSEL+:2] == 2'b11) ? 2'h0 : pwdata[mdo_pkg::F_TSEL+:2];
            end
            mdo_pkg::A_SRC: begin
               src[0] <= (pwdata[2:0] > mdo_pkg::SRC_LAST) ? mdo_pkg::SRC_NONE : pwdata[2:0];
               src[1] <= (pwdata[mdo_pkg::F_SRC1+:3] > mdo_pkg::SRC_LAST) ? mdo_pkg::SRC_NONE
                                                                           : pwdata[mdo_pkg::F_SRC1+:3];
            end
            mdo_pkg::A_FREQ: begin
               fmin <= (pwdata[7:0] < mdo_pkg::FMIN_LO) ? mdo_pkg::FMIN_LO : pwdata[7:0];
               if (pwdata[mdo_pkg::F_FMAX+:16] < 16'(mdo_pkg::FMAX_LO)) begin
                  fmax <= mdo_pkg::FMAX_LO;
               end else if (pwdata[mdo_pkg::F_FMAX+:16] > 16'(mdo_pkg::FMAX_HI)) begin
                  fmax <= mdo_pkg::FMAX_HI;
               end else begin
                  fmax <= pwdata[mdo_pkg::F_FMAX+:mdo_pkg::HZW];
               end
            end
            mdo_pkg::A_PWM:  base_sel <= pwdata[2:0];
            mdo_pkg::A_STIM: begin
               stim_val <= pwdata[15:0];
               stim_pin <= pwdata[mdo_pkg::F_SPIN];
               stim_on  <= pwdata[mdo_pkg::F_SON];   // set applies, clear returns to measured
            end
            mdo_pkg::A_TOFF: trim_off  <= pwdata[15:0];
            mdo_pkg::A_TGN:  trim_gain <= pwdata[15:0];
            mdo_pkg::A_TSOT: trim_sot  <= pwdata[15:0];
            default: ;
         endcase
      end
   end

   // read data captured in the setup cycle, stable through the access phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0;
      end else if (rd_en) begin
         unique case (paddr)
            mdo_pkg::A_CTRL: prdata <= {26'h0, trim_sel, trim_en, map_inv, out_type};
            mdo_pkg::A_SRC:  prdata <= {25'h0, src[1], 1'b0, src[0]};
            mdo_pkg::A_FREQ: prdata <= {2'h0, fmax, 8'h0, fmin};
            mdo_pkg::A_PWM:  prdata <= {29'h0, base_sel};
            mdo_pkg::A_STIM: prdata <= {stim_on, 14'h0, stim_pin, stim_val};
            mdo_pkg::A_TOFF: prdata <= {16'h0, trim_off};
            mdo_pkg::A_TGN:  prdata <= {16'h0, trim_gain};
            mdo_pkg::A_TSOT: prdata <= {16'h0, trim_sot};
            mdo_pkg::A_STAT: prdata <= {2'h0, drv[1].hz, 2'h0, drv[0].hz};
            default:         prdata <= 32'h0;
         endcase
      end
   end

   // temperature trim: offset + gain*t + sot*t^2, t centred on mid scale
   always_comb begin
      t_dev     = $signed({1'b0, chan.val[3 + trim_sel]}) - $signed({1'b0, mdo_pkg::T_MID});
      t_sq      = (32'(t_dev) * 32'(t_dev)) >>> 15;
      trim_corr = 32'(trim_off) + ((32'(trim_gain) * 32'(t_dev)) >>> 16)
                + ((32'(trim_sot) * t_sq) >>> 16);
   end

   for (genvar i = 0; i < 2; i++) begin : g_pin
      logic               ovr;
      logic               used;
      logic [15:0]        val;
      logic [29:0]        prod;
      logic [13:0]        fm_hz;
      logic signed [31:0] fm_trim;
      logic [16:0]        duty;
      mdo_pkg::mdo_drive_t next_drv;

      assign ovr  = stim_on && (stim_pin == 1'(i));
      assign used = ovr || (src[i] != mdo_pkg::SRC_NONE);
      assign val  = ovr ? stim_val : (used ? chan.val[src[i] - 3'h1] : 16'h0);

      assign prod  = 30'(fmax - 14'(fmin)) * 30'(val);
      assign fm_hz = 14'(fmin) + prod[29:16];
      assign fm_trim = trim_en ? $signed(32'(fm_hz)) + trim_corr : $signed(32'(fm_hz));

      // duty mapping; full scale saturates so the pin stays steady
      always_comb begin
         duty = (val == mdo_pkg::V_FULL) ? mdo_pkg::D_FULL : {1'b0, val};
         if (map_inv) begin
            duty = mdo_pkg::D_FULL - duty;
         end
      end

      always_comb begin
         next_drv.en   = used && (out_type != mdo_pkg::MDO_OFF);
         next_drv.pwm  = (out_type == mdo_pkg::MDO_PWM);
         next_drv.duty = duty;
         if (out_type == mdo_pkg::MDO_PWM) begin
            next_drv.hz = mdo_pkg::BASE_HZ[base_sel];
         end else if (fm_trim < 32'sd1) begin
            next_drv.hz = 14'h1;           // trim never stalls the output
         end else if (fm_trim > $signed(32'(mdo_pkg::HZ_SAT))) begin
            next_drv.hz = mdo_pkg::HZ_SAT;
         end else begin
            next_drv.hz = fm_trim[13:0];
         end
      end

      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            drv[i] <= '0;
         end else begin
            drv[i] <= next_drv;
         end
      end

      // the pin is only driven while a source is active; unused pins float
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            pin_oe[i] <= 1'b0;
         end else begin
            pin_oe[i] <= drv[i].en;
         end
      end

      mdo_gen u_gen (
         .pclk    (pclk),
         .presetn (presetn),
         .drv     (drv[i]),
         .pin     (pin_out[i]),
         .phase   ()
      );

      property p_off_low;
         @(posedge pclk) disable iff (!presetn)
         (out_type == mdo_pkg::MDO_OFF)[*3] |-> !pin_out[i] && !pin_oe[i];
      endproperty
      a_off_low: assert property (p_off_low) else $error("pin active with modulation off");

      property p_unused;
         @(posedge pclk) disable iff (!presetn)
         (!used)[*3] |-> !pin_oe[i];
      endproperty
      a_unused: assert property (p_unused) else $error("unused pin driven");

      property p_full_high;
         @(posedge pclk) disable iff (!presetn)
         (out_type == mdo_pkg::MDO_PWM && used && !map_inv && val == mdo_pkg::V_FULL)[*3] |-> pin_out[i];
      endproperty
      a_full_high: assert property (p_full_high) else $error("full stimulus not steady high");

      property p_full_low;
         @(posedge pclk) disable iff (!presetn)
         (out_type == mdo_pkg::MDO_PWM && map_inv && val == mdo_pkg::V_FULL)[*3] |-> !pin_out[i];
      endproperty
      a_full_low: assert property (p_full_low) else $error("inverted full stimulus not steady low");

      // watched at the pin so a broken bypass path cannot hide behind the mux
      property p_stim;
         @(posedge pclk) disable iff (!presetn)
         (out_type == mdo_pkg::MDO_PWM && ovr && stim_val == mdo_pkg::V_FULL)[*3] |-> pin_out[i] == !map_inv;
      endproperty
      a_stim: assert property (p_stim) else $error("stimulus not bypassing channel");

      property p_fm_range;
         @(posedge pclk) disable iff (!presetn)
         (out_type == mdo_pkg::MDO_FM && next_drv.en && !trim_en) |=> drv[i].hz >= 14'($past(fmin))
            && drv[i].hz <= $past(fmax);
      endproperty
      a_fm_range: assert property (p_fm_range) else $error("fm frequency outside range");

      property p_trim_off;
         @(posedge pclk) disable iff (!presetn)
         (out_type == mdo_pkg::MDO_FM && !trim_en && val == 16'h0) |=> drv[i].hz == 14'($past(fmin));
      endproperty
      a_trim_off: assert property (p_trim_off) else $error("untrimmed zero value not at min");

      c_fm:   cover property (@(posedge pclk) disable iff (!presetn) out_type == mdo_pkg::MDO_FM && pin_out[i]);
      c_pwm:  cover property (@(posedge pclk) disable iff (!presetn) out_type == mdo_pkg::MDO_PWM && $rose(pin_out[i]));
      c_stim: cover property (@(posedge pclk) disable iff (!presetn) ovr && pin_oe[i]);
   end

   property p_limits;
      @(posedge pclk) disable iff (!presetn)
      fmin >= mdo_pkg::FMIN_LO && fmax >= mdo_pkg::FMAX_LO && fmax <= mdo_pkg::FMAX_HI;
   endproperty
   a_limits: assert property (p_limits) else $error("frequency limits out of band");

   property p_base;
      @(posedge pclk) disable iff (!presetn)
      (out_type == mdo_pkg::MDO_PWM) |=> drv[0].hz == mdo_pkg::BASE_HZ[$past(base_sel)];
   endproperty
   a_base: assert property (p_base) else $error("pwm base frequency wrong");
endmodule

// ===== tb_top.sv
// testbench: apb register tests and pin checks of the modulated output
`timescale 1ns/100ps
module tb_top;
   logic               pclk = 1'b0;
   logic               presetn = 1'b0;
   logic               psel = 1'b0;
   logic               penable = 1'b0;
   logic               pwrite = 1'b0;
   logic [7:0]         paddr = 8'h00;
   logic [31:0]        pwdata = 32'h0;
   logic [31:0]        prdata;
   logic               pready;
   logic               pslverr;
   mdo_pkg::mdo_chan_t chan = '0;
   logic [1:0]         pin_out;
   logic [1:0]         pin_oe;
   logic [31:0]        period;
   logic [31:0]        high_t;
   int                 n_mismatch = 0;
   int                 cmp_count = 0;
   logic [31:0]        q;
   logic               err;
   // 200, 500, 1000, 1500, 2000, 2500, 5000 and 15000 hz
   logic [13:0]        base_tab [8] = '{14'h00c8, 14'h01f4, 14'h03e8, 14'h05dc,
                                        14'h07d0, 14'h09c4, 14'h1388, 14'h3a98};

   mdo_top mdo_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .chan(chan), .pin_out(pin_out), .pin_oe(pin_oe));
   mdo_meter mdo_meter_i (.clk(pclk), .rst_n(presetn), .pin(pin_out[0]), .period(period), .high_t(high_t));

   // 250 mhz clock
   initial begin
      forever #2 pclk = ~pclk;
   end

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         $display("wrong value %s expected %h seen %h", what, exp, seen);
         n_mismatch++;
      end
   endtask

   // one apb transfer; holds the request until pready is seen high
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rd(input string what, input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      check(what, q, exp);
   endtask

   // pin must hold one level for a whole window
   task automatic steady(input string what, input int idx, input logic lvl);
      logic ok;
      ok = 1'b1;
      repeat (2000) begin
         @(posedge pclk);
         if (pin_out[idx] !== lvl)
            ok = 1'b0;
      end
      check(what, {31'h0, ok}, 32'h1);
   endtask

   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // watchdog sized a little above the longest expected run (about 48200 cycles)
   initial begin
      repeat (60000) @(posedge pclk);
      n_mismatch++;
      end_sim();
   end

   // main sequence
   initial begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      rd("ctrl reset", mdo_pkg::A_CTRL, 32'h0);
      rd("freq reset", mdo_pkg::A_FREQ, 32'h03e8_0064);
      rd("pwm reset", mdo_pkg::A_PWM, 32'h2);
      rd("unmapped", 8'h24, 32'h0);
      check("unmapped err", {31'h0, err}, 32'h1);
      check("oe reset", {30'h0, pin_oe}, 32'h0);
      // out-of-range limits clamp, in-range limits stick
      apb(1'b1, mdo_pkg::A_FREQ, 32'h4e20_0032);
      rd("freq clamp", mdo_pkg::A_FREQ, 32'h2710_0064);
      apb(1'b1, mdo_pkg::A_FREQ, 32'h01f4_00ff);
      rd("freq clamp lo", mdo_pkg::A_FREQ, 32'h03e8_00ff);
      // fm over 100..10000 hz, settings written before channels move; pin 1 follows temp channel 2
      apb(1'b1, mdo_pkg::A_FREQ, 32'h2710_0064);
      apb(1'b1, mdo_pkg::A_SRC, 32'h51);
      apb(1'b1, mdo_pkg::A_CTRL, 32'h1);
      rd("fm zero", mdo_pkg::A_STAT, 32'h0064_0064);
      check("oe fm", {30'h0, pin_oe}, 32'h3);
      check("mapped err", {31'h0, err}, 32'h0);
      chan.val[0] <= 16'h8000;
      repeat (4) @(posedge pclk);
      rd("fm half", mdo_pkg::A_STAT, 32'h0064_13ba);
      chan.val[0] <= 16'hffff;
      repeat (4) @(posedge pclk);
      rd("fm full", mdo_pkg::A_STAT, 32'h0064_270f);
      // trim: temp channel 1 in use before trim is enabled; one correction serves both pins
      chan.val[0] <= 16'h0000;
      chan.val[3] <= 16'hc000;
      apb(1'b1, mdo_pkg::A_TOFF, 32'h32);
      apb(1'b1, mdo_pkg::A_TGN, 32'h100);
      apb(1'b1, mdo_pkg::A_TSOT, 32'h10);
      apb(1'b1, mdo_pkg::A_CTRL, 32'h9);
      repeat (4) @(posedge pclk);
      rd("fm trim", mdo_pkg::A_STAT, 32'h00d8_00d8);
      // every pwm base frequency, both pins
      apb(1'b1, mdo_pkg::A_CTRL, 32'h2);
      for (int i = 0; i < 8; i++) begin
         apb(1'b1, mdo_pkg::A_PWM, i);
         rd("pwm base", mdo_pkg::A_STAT, {2'h0, base_tab[i], 2'h0, base_tab[i]});
      end
      chan.val[0] <= 16'hffff;
      chan.val[4] <= 16'hffff;
      repeat (4) @(posedge pclk);
      steady("pwm full pin0", 0, 1'b1);
      steady("pwm full pin1", 1, 1'b1);
      apb(1'b1, mdo_pkg::A_CTRL, 32'h6);
      repeat (4) @(posedge pclk);
      steady("pwm inverted", 0, 1'b0);
      // applied stimulus overrides a zero channel
      apb(1'b1, mdo_pkg::A_CTRL, 32'h2);
      chan.val[0] <= 16'h0000;
      apb(1'b1, mdo_pkg::A_STIM, 32'h8000_ffff);
      repeat (4) @(posedge pclk);
      steady("stimulus", 0, 1'b1);
      apb(1'b1, mdo_pkg::A_STIM, 32'h0);
      // half scale at 15 khz: period 16667 cycles, half of it high
      chan.val[0] <= 16'h8000;
      repeat (40000) @(posedge pclk);
      check("pwm period", {31'h0, period > 32'h4074 && period < 32'h41c2}, 32'h1);
      check("pwm duty", {31'h0, high_t * 2 > period - 32'hc8 && high_t * 2 < period + 32'hc8}, 32'h1);
      apb(1'b1, mdo_pkg::A_CTRL, 32'h0);
      repeat (4) @(posedge pclk);
      check("oe off", {30'h0, pin_oe}, 32'h0);
      end_sim();
   end
endmodule
